// >>> verilog/lcd_cfg.svh
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH
// Notes on behaviour
// - Six commons, thirty-two segments, 192 segments
// - Dynamic drive, one-third bias, four levels
// - Drive levels only while supply bit set
// - DC segments act as plain port pins
// - Force-on drives on waveform on every segment but DC segments
// - Force-off drives off waveform on every segment but DC segments
// - Both clear: segments follow display memory
// - Force-on wins over force-off
// - Duty field picks 1/4, 1/5, 1/6, 1/3
// - Frame rates 42.7, 25.6, 32 Hz
// - Static select works only with half-bias option
// - Static: any common bit set gives on
// - Static: all bits clear give dynamic off
// - Static select ignored on other supply options
// - Memory F000H-F02FH, bits mapped at build time
// - Memory bit one on, zero off
// - Memory read/write, spare words general purpose

`define LCD_MEM_BASE 16'hF000
`define LCD_MEM_LAST 16'hF02F
`define LCD_MEM_WORDS 48
`define LCD_CTRL_ADDR 16'hFF60
`define LCD_DUTY_ADDR 16'hFF61
`define LCD_STATUS_ADDR 16'hFF62
`define LCD_CTRL_SUPPLY_BIT 0
`define LCD_CTRL_STATIC_BIT 1
`define LCD_CTRL_OFF_BIT 2
`define LCD_CTRL_ON_BIT 3
`define LCD_DUTY_LOW_BIT 0
`define LCD_DUTY_HIGH_BIT 1
`define LCD_CTRL_RESET 4'h0
`define LCD_DUTY_RESET 2'h0
`define LCD_SLOW_HZ 32768
`define LCD_COM_TICKS_SIX 128
`define LCD_COM_TICKS_OTHER 256
`define LCD_COMMONS_THIRD 3'h3
`define LCD_COMMONS_FOURTH 3'h4
`define LCD_COMMONS_FIFTH 3'h5
`define LCD_COMMONS_SIXTH 3'h6
`define LVL_VSS 2'h0
`define LVL_VC1 2'h1
`define LVL_VC2 2'h2
`define LVL_VC3 2'h3
`endif

// >>> verilog/lcd_pkg.sv
package lcd_pkg;
  typedef enum logic [1:0] {
    DUTY_FOURTH = 2'h0,
    DUTY_FIFTH = 2'h1,
    DUTY_SIXTH = 2'h2,
    DUTY_THIRD = 2'h3
  } duty_e;

  typedef enum logic [1:0] {
    SUPPLY_INTERNAL = 2'h0,
    SUPPLY_EXT_THIRD_HIGH = 2'h1,
    SUPPLY_EXT_THIRD_LOW = 2'h2,
    SUPPLY_EXT_HALF = 2'h3
  } supply_option_e;

  typedef logic [1:0] level_t;

  typedef struct packed {
    logic [7:0] tick_count;
    logic [2:0] common_index;
    logic polarity;
  } divider_state_s;

  typedef struct packed {
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic lcd_supply_on;
    logic static_drive_select;
    logic force_all_segments_off;
    logic force_all_segments_on;
    duty_e duty;
    logic [3:0] rdata;
    logic [11:0] com_level;
    logic [63:0] seg_level;
  } control_state_s;

  // Flat display-memory bit index for each segment and common
  function automatic logic [1535:0] default_seg_map();
    logic [1535:0] map;
    map = '0;
    for (int i = 0; i < 192; i++)
    begin
      map[i*8 +: 8] = 8'(i);
    end
    return map;
  endfunction : default_seg_map
endpackage : lcd_pkg

// >>> verilog/lcd_frame_divider.sv
`timescale 1ns/100ps
`include "lcd_cfg.svh"

module lcd_frame_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow_tick,
  input wire lcd_pkg::duty_e duty,
  output logic [2:0] common_index,
  output logic polarity
);
  lcd_pkg::divider_state_s q;
  lcd_pkg::divider_state_s next_q;
  logic [7:0] last_tick;
  logic [2:0] commons;

  always_comb
  begin
    next_q = q;
    // 1/6 steps twice as fast so every duty but 1/5 and 1/4 gives 768 ticks a frame
    last_tick = (duty == lcd_pkg::DUTY_SIXTH) ? 8'(`LCD_COM_TICKS_SIX - 1) : 8'(`LCD_COM_TICKS_OTHER - 1);
    unique case (duty)
      lcd_pkg::DUTY_THIRD: commons = `LCD_COMMONS_THIRD;
      lcd_pkg::DUTY_SIXTH: commons = `LCD_COMMONS_SIXTH;
      lcd_pkg::DUTY_FIFTH: commons = `LCD_COMMONS_FIFTH;
      lcd_pkg::DUTY_FOURTH: commons = `LCD_COMMONS_FOURTH;
    endcase
    if (slow_tick)
    begin
      if (q.tick_count >= last_tick)
      begin
        next_q.tick_count = 8'h00;
        // Wrap also catches an index stranded by a duty change
        if (q.common_index >= commons - 3'h1)
        begin
          next_q.common_index = 3'h0;
          next_q.polarity = ~q.polarity;
        end
        else
        begin
          next_q.common_index = q.common_index + 3'h1;
        end
      end
      else
      begin
        next_q.tick_count = q.tick_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign common_index = q.common_index;
  assign polarity = q.polarity;
endmodule : lcd_frame_divider

// >>> verilog/lcd_segment_driver_control.sv
`timescale 1ns/100ps
`include "lcd_cfg.svh"

module lcd_segment_driver_control #(
  parameter lcd_pkg::supply_option_e SUPPLY_OPTION = lcd_pkg::SUPPLY_INTERNAL,
  parameter logic [15:0] DC_PAIR_MASK = 16'h0000,
  parameter logic [1535:0] SEG_MAP = lcd_pkg::default_seg_map()
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [3:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [3:0] RDATA,
  input wire logic SLOW_OSCILLATOR,
  output logic [11:0] COMMON_OUTPUTS,
  output logic [63:0] SEGMENT_OUTPUTS,
  output logic DRIVE_VOLTAGE_LEVELS_EN
);
  lcd_pkg::control_state_s q;
  lcd_pkg::control_state_s next_q;
  logic [3:0] mem [`LCD_MEM_WORDS];
  logic [191:0] mem_flat;
  logic mem_hit;
  logic [5:0] mem_idx;
  logic slow_tick;
  logic [2:0] common_index;
  logic polarity;
  logic static_active;
  logic [11:0] com_next;
  logic [63:0] seg_next;
  logic [31:0] any_on;
  logic [31:0] cur_on;

  assign mem_hit = (ADDR >= `LCD_MEM_BASE) && (ADDR <= `LCD_MEM_LAST);
  assign mem_idx = ADDR[5:0];
  assign slow_tick = q.osc_sync & ~q.osc_prev;
  // Static only exists where the half-bias supply is fitted
  assign static_active = q.static_drive_select && (SUPPLY_OPTION == lcd_pkg::SUPPLY_EXT_HALF);

  lcd_frame_divider u_divider (
    .clk(CLK),
    .rst(RST),
    .slow_tick(slow_tick),
    .duty(q.duty),
    .common_index(common_index),
    .polarity(polarity)
  );

  // No reset: contents survive reset and must be set up by software
  always_ff @(posedge CLK)
  begin
    if (WR && mem_hit)
    begin
      mem[mem_idx] <= WDATA;
    end
  end

  generate
    for (genvar w = 0; w < `LCD_MEM_WORDS; w++)
    begin : g_flat
      assign mem_flat[w*4 +: 4] = mem[w];
    end

    // Commons: selected one gets the full swing, the rest the inner levels
    for (genvar c = 0; c < 6; c++)
    begin : g_com
      always_comb
      begin
        if (!q.lcd_supply_on)
        begin
          com_next[c*2 +: 2] = `LVL_VSS;
        end
        else if (static_active || common_index == 3'(c))
        begin
          com_next[c*2 +: 2] = polarity ? `LVL_VSS : `LVL_VC3;
        end
        else
        begin
          com_next[c*2 +: 2] = polarity ? `LVL_VC2 : `LVL_VC1;
        end
      end
    end

    for (genvar s = 0; s < 32; s++)
    begin : g_seg
      logic [5:0] bits;
      logic on;
      for (genvar c = 0; c < 6; c++)
      begin : g_bit
        assign bits[c] = mem_flat[SEG_MAP[(s*6+c)*8 +: 8]];
      end
      assign any_on[s] = |bits;
      assign cur_on[s] = (common_index < 3'h6) ? bits[common_index] : 1'b0;
      always_comb
      begin
        if (q.force_all_segments_on)
        begin
          on = 1'b1;
        end
        else if (q.force_all_segments_off)
        begin
          on = 1'b0;
        end
        else
        begin
          on = static_active ? any_on[s] : cur_on[s];
        end
        if (DC_PAIR_MASK[s/2])
        begin
          // DC pins ignore the supply bit and forcing, like a port pin
          seg_next[s*2 +: 2] = bits[0] ? `LVL_VC3 : `LVL_VSS;
        end
        else if (!q.lcd_supply_on)
        begin
          seg_next[s*2 +: 2] = `LVL_VSS;
        end
        else if (on)
        begin
          seg_next[s*2 +: 2] = polarity ? `LVL_VC3 : `LVL_VSS;
        end
        else
        begin
          seg_next[s*2 +: 2] = polarity ? `LVL_VC1 : `LVL_VC2;
        end
      end
    end
  endgenerate

  always_comb
  begin
    next_q = q;
    next_q.osc_meta = SLOW_OSCILLATOR;
    next_q.osc_sync = q.osc_meta;
    next_q.osc_prev = q.osc_sync;
    if (WR && ADDR == `LCD_CTRL_ADDR)
    begin
      next_q.lcd_supply_on = WDATA[`LCD_CTRL_SUPPLY_BIT];
      next_q.static_drive_select = WDATA[`LCD_CTRL_STATIC_BIT];
      next_q.force_all_segments_off = WDATA[`LCD_CTRL_OFF_BIT];
      next_q.force_all_segments_on = WDATA[`LCD_CTRL_ON_BIT];
    end
    if (WR && ADDR == `LCD_DUTY_ADDR)
    begin
      next_q.duty = lcd_pkg::duty_e'({WDATA[`LCD_DUTY_HIGH_BIT], WDATA[`LCD_DUTY_LOW_BIT]});
    end
    next_q.rdata = 4'h0;
    if (RD)
    begin
      if (mem_hit)
      begin
        next_q.rdata = mem[mem_idx];
      end
      else if (ADDR == `LCD_CTRL_ADDR)
      begin
        next_q.rdata = {q.force_all_segments_on, q.force_all_segments_off, q.static_drive_select,
                        q.lcd_supply_on};
      end
      else if (ADDR == `LCD_DUTY_ADDR)
      begin
        next_q.rdata = {2'h0, q.duty};
      end
      else if (ADDR == `LCD_STATUS_ADDR)
      begin
        next_q.rdata = {polarity, common_index};
      end
    end
    next_q.com_level = com_next;
    next_q.seg_level = seg_next;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign RDATA = q.rdata;
  assign COMMON_OUTPUTS = q.com_level;
  assign SEGMENT_OUTPUTS = q.seg_level;
  assign DRIVE_VOLTAGE_LEVELS_EN = q.lcd_supply_on;

  // Helper for assertions: where the last write went
  logic [5:0] wr_idx;
  logic [3:0] wr_data;
  logic wr_valid;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wr_valid <= 1'b0;
      wr_idx <= 6'h00;
      wr_data <= 4'h0;
    end
    else
    begin
      wr_valid <= WR && mem_hit;
      wr_idx <= mem_idx;
      wr_data <= WDATA;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  AST_SUPPLY_OFF_QUIET: assert property (
    !q.lcd_supply_on |=> COMMON_OUTPUTS == 12'h000)
    else $error("Commons driven while supply is off");

  AST_FORCE_ON: assert property (
    q.lcd_supply_on && q.force_all_segments_on && !DC_PAIR_MASK[1]
    |=> SEGMENT_OUTPUTS[5:4] == ($past(polarity) ? `LVL_VC3 : `LVL_VSS))
    else $error("Force-on did not give on waveform");

  AST_FORCE_OFF: assert property (
    q.lcd_supply_on && q.force_all_segments_off && !q.force_all_segments_on && !DC_PAIR_MASK[1]
    |=> SEGMENT_OUTPUTS[5:4] == ($past(polarity) ? `LVL_VC1 : `LVL_VC2))
    else $error("Force-off did not give off waveform");

  AST_FORCE_PRIORITY: assert property (
    q.lcd_supply_on && q.force_all_segments_on && q.force_all_segments_off && !DC_PAIR_MASK[31]
    |=> SEGMENT_OUTPUTS[63:62] != ($past(polarity) ? `LVL_VC1 : `LVL_VC2))
    else $error("Force-off won over force-on");

  AST_NORMAL_FOLLOWS_MEM: assert property (
    q.lcd_supply_on && !q.force_all_segments_on && !q.force_all_segments_off && !static_active
    && !DC_PAIR_MASK[1] && cur_on[2]
    |=> SEGMENT_OUTPUTS[5:4] == ($past(polarity) ? `LVL_VC3 : `LVL_VSS))
    else $error("Segment does not follow memory");

  // An index stranded by a duty change may linger, but once in range it stays there
  AST_DUTY_RANGE: assert property (
    q.duty == lcd_pkg::DUTY_THIRD && common_index < 3'h3 |=> common_index < 3'h3)
    else $error("Common beyond 1/3 duty range");

  AST_STATIC_ON: assert property (
    q.lcd_supply_on && static_active && !q.force_all_segments_on && !q.force_all_segments_off
    && !DC_PAIR_MASK[0] && any_on[0]
    |=> SEGMENT_OUTPUTS[1:0] == ($past(polarity) ? `LVL_VC3 : `LVL_VSS))
    else $error("Static segment not on");

  AST_STATIC_OFF: assert property (
    q.lcd_supply_on && static_active && !q.force_all_segments_on && !DC_PAIR_MASK[0] && !any_on[0]
    |=> SEGMENT_OUTPUTS[1:0] == ($past(polarity) ? `LVL_VC1 : `LVL_VC2))
    else $error("Static segment not off");

  AST_STATIC_IGNORED: assert property (
    SUPPLY_OPTION != lcd_pkg::SUPPLY_EXT_HALF && q.lcd_supply_on && common_index != 3'h0
    |=> COMMON_OUTPUTS[1:0] inside {`LVL_VC1, `LVL_VC2})
    else $error("Static select acted without half-bias supply");

  AST_MEM_READBACK: assert property (
    wr_valid && RD && mem_hit && mem_idx == wr_idx |=> RDATA == $past(wr_data))
    else $error("Display memory read-back mismatch");

  AST_FRAME_WRAP: assert property (
    $changed(polarity) |-> common_index == 3'h0 && $past(common_index) != 3'h0 || $past(q.duty) != q.duty
    || common_index == 3'h0)
    else $error("Polarity changed off a frame boundary");

  COV_FORCE_BOTH: cover property (q.force_all_segments_on && q.force_all_segments_off);
  COV_STATIC: cover property (static_active && q.lcd_supply_on);
  COV_SIXTH_WRAP: cover property (q.duty == lcd_pkg::DUTY_SIXTH && common_index == 3'h5 ##[1:300] common_index == 3'h0);
  COV_MEM_READ: cover property (RD && mem_hit ##1 RDATA != 4'h0);
endmodule : lcd_segment_driver_control

// >>> test/lcd_glass_panel.sv
`timescale 1ns/100ps
module lcd_glass_panel (
  input wire logic [11:0] com,
  input wire logic [63:0] seg,
  output logic [2:0] sel,
  output logic [31:0] lit
);
  logic [1:0] sel_lvl;
  always_comb
  begin
    sel = 3'h0;
    sel_lvl = com[1:0];
    // Selected common sits on an outer level
    for (int c = 5; c >= 0; c--)
    begin
      if (com[2*c +: 2] == 2'h0 || com[2*c +: 2] == 2'h3)
      begin
        sel = 3'(c);
        sel_lvl = com[2*c +: 2];
      end
    end
    // Only the full three-step swing lights a segment
    for (int s = 0; s < 32; s++)
    begin
      lit[s] = (seg[2*s +: 2] ^ sel_lvl) == 2'h3;
    end
  end
endmodule : lcd_glass_panel

// >>> test/test_lcd_segment_driver_control.sv
`timescale 1ns/100ps
module test_lcd_segment_driver_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [3:0] wdata = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc = 1'b0;
  logic run = 1'b0;
  logic [1:0] div = 2'h0;
  logic [3:0] rdata;
  logic [11:0] com;
  logic [63:0] seg;
  logic en;
  logic [2:0] sel;
  logic [31:0] lit;
  logic [3:0] mem [48];
  int n_fail = 0;
  int comparisons = 0;
  int ticks = 0;
  int top;
  int t0;
  lcd_segment_driver_control #(.DC_PAIR_MASK(16'h0001)) u_dut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SLOW_OSCILLATOR(osc), .COMMON_OUTPUTS(com),
    .SEGMENT_OUTPUTS(seg), .DRIVE_VOLTAGE_LEVELS_EN(en));
  lcd_glass_panel u_panel (.com(com), .seg(seg), .sel(sel), .lit(lit));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Slow clock sped up to 8 cycles; stopping it freezes the common
  always @(posedge clk)
  begin
    if (run)
      div <= div + 2'h1;
    if (run && div == 2'h3)
      osc <= ~osc;
  end
  always @(posedge osc) ticks++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_fail++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, input logic [3:0] want);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, want);
    @(posedge clk);
  endtask : rd_reg
  function automatic logic bit_of(input int s, input int c);
    return mem[(s * 6 + c) / 4][(s * 6 + c) % 4];
  endfunction : bit_of
  task automatic to_zero();
    int g = 0;
    while (sel === 3'h0 && g < 30000)
    begin
      @(posedge clk);
      g++;
    end
    while (sel !== 3'h0 && g < 30000)
    begin
      @(posedge clk);
      if (int'(sel) > top)
        top = int'(sel);
      g++;
    end
  endtask : to_zero
  task automatic frame(input logic [1:0] d, input int want, input logic [2:0] last);
    wr_reg(16'hFF61, {2'h0, d});
    rd_reg(16'hFF61, {2'h0, d});
    to_zero();
    t0 = ticks;
    top = 0;
    to_zero();
    chk(ticks - t0, want);
    chk(top, last);
  endtask : frame
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial
  begin
    #1200000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h073e5e5e));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(16'hFF60, 4'h0);
    chk(en, 1'b0);
    chk(com, 12'h000);
    $display("reset test done");
    // Memory is never cleared, so it is filled before the panel is powered
    for (int i = 0; i < 48; i++)
    begin
      mem[i] = 4'($urandom);
      wr_reg(16'hF000 + 16'(i), mem[i]);
    end
    // Write then read with no gap, so the read-back assertion is exercised
    mem[5] = 4'hA;
    wr <= 1'b1;
    addr <= 16'hF005;
    wdata <= 4'hA;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, 4'hA);
    @(posedge clk);
    for (int i = 47; i >= 0; i--)
      rd_reg(16'hF000 + 16'(i), mem[i]);
    wr_reg(16'hF030, 4'hF);
    rd_reg(16'hF030, 4'h0);
    rd_reg(16'hEFFF, 4'h0);
    chk(seg[1:0], {2{bit_of(0, 0)}});
    chk(seg[3:2], {2{bit_of(1, 0)}});
    $display("memory test done");
    wr_reg(16'hFF60, 4'h1);
    chk(en, 1'b1);
    run <= 1'b1;
    frame(2'h2, 768, 3'h5);
    frame(2'h3, 768, 3'h2);
    frame(2'h1, 1280, 3'h4);
    frame(2'h0, 1024, 3'h3);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    $display("duty test done");
    // Static select is set throughout and must be ignored on this supply option
    for (int f = 0; f < 4; f++)
    begin
      wr_reg(16'hFF60, {2'(f), 2'h3});
      // Levels are registered one edge after the control bits
      @(negedge clk);
      for (int s = 2; s < 32; s++)
        chk(lit[s], f[1] | (~f[0] & bit_of(s, int'(sel))));
      @(posedge clk);
    end
    $display("force test done");
    wr_reg(16'hFF60, 4'h0);
    chk(en, 1'b0);
    @(negedge clk);
    chk(com, 12'h000);
    chk(seg[63:4], 60'h0);
    chk(seg[1:0], {2{bit_of(0, 0)}});
    $display("supply test done");
    end_of_test();
  end
endmodule : test_lcd_segment_driver_control
